// ===== core/gbcd_consts.svh
// gbcd_consts.svh: register offsets, field positions and bus command codes
// assumes: included by bare name from every design file that needs it
`ifndef GBCD_CONSTS_SVH
`define GBCD_CONSTS_SVH
`define GBCD_OFF_CTRL  12'h000
`define GBCD_OFF_STAT  12'h004
`define GBCD_OFF_RXD   12'h008
`define GBCD_OFF_EVT   12'h00C
`define GBCD_CTRL_SRQ  8
`define GBCD_EVT_CLR   0
`define GBCD_EVT_TRIG  1
`define GBCD_EVT_IFC   2
`define GBCD_CMD_GTL   7'h01
`define GBCD_CMD_SDC   7'h04
`define GBCD_CMD_GET   7'h08
`define GBCD_CMD_LLO   7'h11
`define GBCD_CMD_DCL   7'h14
`define GBCD_CMD_SPE   7'h18
`define GBCD_CMD_SPD   7'h19
`define GBCD_CMD_UNL   7'h3F
`define GBCD_CMD_UNT   7'h5F
`define GBCD_GRP_MASK  7'h60
`define GBCD_GRP_LAG   7'h20
`define GBCD_GRP_TAG   7'h40
`define GBCD_GRP_SCG   7'h60
`endif

// ===== core/gbcd_pkg.sv
// gbcd_pkg: state types of the bus command decoder
// assumes: compiled before every other design file
package gbcd_pkg;
  typedef enum logic [1:0] {AH_IDLE, AH_READY, AH_HOLD, AH_ACCEPT} gbcd_ah_state_t;

  typedef struct packed {
    gbcd_ah_state_t st;
    logic [7:0]     data;
    logic           atn;
    logic           eoi;
  } gbcd_ah_t;

  typedef struct packed {
    logic        listen;
    logic        talk;
    logic        remote;
    logic        lockout;
    logic        spoll;
    logic        srq;
    logic [4:0]  paddr;
    logic [7:0]  rx_data;
    logic        rx_eoi;
    logic        rx_full;
    logic [2:0]  evt;
    logic        clr_p;
    logic        trig_p;
    logic        msg_v;
    logic [7:0]  msg_d;
    logic        msg_eoi;
    logic        key_q;
    logic        ifc_q;
    logic        dp_wr;
    logic [11:0] dp_addr;
    logic [31:0] rdata;
  } gbcd_core_t;
endpackage

// ===== core/gbcd_byte_if.sv
// gbcd_byte_if: one accepted bus byte from the acceptor to the decoder
// assumes: both ends on ref_clk_i; a byte moves when valid and ready are high
`timescale 1ns/1ps
interface gbcd_byte_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  logic       atn;
  logic       eoi;
  modport src (output valid, data, atn, eoi, input ready);
  modport snk (input valid, data, atn, eoi, output ready);
endinterface

// ===== core/gbcd_sync.sv
// gbcd_sync: two-flop synchroniser for a vector of pin levels
// assumes: inputs are static for several clocks; no multi-bit coherence needed
`timescale 1ns/1ps
module gbcd_sync #(
  parameter int W = 14
) (
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gbcd_sync_t;

  gbcd_sync_t q, d;

  always_comb begin
    d    = q;
    d.s1 = async_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) q <= '0;
    else q <= d;
  end

  assign sync_o = q.s2;
endmodule // gbcd_sync

// ===== core/gbcd_acceptor.sv
// gbcd_acceptor: acceptor half of the three-wire byte handshake
// assumes: synchronised true-level inputs; sink may stall by holding ready low
`timescale 1ns/1ps
module gbcd_acceptor (
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       active_i,
  input  wire logic       ifc_i,
  input  wire logic       dav_i,
  input  wire logic       atn_i,
  input  wire logic       eoi_i,
  input  wire logic [7:0] dio_i,
  output logic            nrfd_oe_n_o,
  output logic            ndac_oe_n_o,
  gbcd_byte_if.src        byte_o
);
  gbcd_pkg::gbcd_ah_t q, d;

  always_comb begin
    d = q;
    case (q.st)
      gbcd_pkg::AH_IDLE: if (active_i && !dav_i) d.st = gbcd_pkg::AH_READY;
      gbcd_pkg::AH_READY: if (dav_i) begin
        d.st   = gbcd_pkg::AH_HOLD;
        d.data = dio_i;
        d.atn  = atn_i;
        d.eoi  = eoi_i;
      end
      gbcd_pkg::AH_HOLD: if (byte_o.ready) d.st = gbcd_pkg::AH_ACCEPT;
      gbcd_pkg::AH_ACCEPT: if (!dav_i) d.st = gbcd_pkg::AH_READY;
      default: d.st = gbcd_pkg::AH_IDLE;
    endcase
    // a byte already held is still delivered when addressing drops
    if (ifc_i || (!active_i && q.st != gbcd_pkg::AH_HOLD)) d.st = gbcd_pkg::AH_IDLE;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) q <= '0;
    else q <= d;
  end

  assign byte_o.valid = (q.st == gbcd_pkg::AH_HOLD);
  assign byte_o.data  = q.data;
  assign byte_o.atn   = q.atn;
  assign byte_o.eoi   = q.eoi;
  // not ready is held from capture until the source drops data valid
  assign nrfd_oe_n_o  = !(q.st == gbcd_pkg::AH_HOLD || q.st == gbcd_pkg::AH_ACCEPT);
  assign ndac_oe_n_o  = !(q.st == gbcd_pkg::AH_READY || q.st == gbcd_pkg::AH_HOLD);

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  capture_hold_a: assert property (
    q.st == gbcd_pkg::AH_READY && dav_i && !ifc_i && active_i
    |=> byte_o.valid && !nrfd_oe_n_o && !ndac_oe_n_o)
    else $error("byte not held after data valid");
  accept_release_a: assert property (
    byte_o.valid && byte_o.ready && !ifc_i
    |=> !nrfd_oe_n_o && ndac_oe_n_o && !byte_o.valid)
    else $error("accept not signalled after take");
endmodule // gbcd_acceptor

// ===== core/gbcd_top.sv
// gbcd_top: bus command decoder of a talker/listener instrument
// assumes: AHB-Lite single word transfers; bus pins are low true and open drain
// Functional notes
// - bytes taken with attention true are commands or addresses, never data.
// - bytes taken with attention false go to the parser as data.
// - every uniline signal is true when its line is low.
// - service request is driven from software request until software or a device clear clears it.
// - remote enable false forces local; true allows remote when addressed.
// - a byte with end-or-identify marks the end of a message.
// - interface clear idles talker, listener and serial poll.
// - universal commands act whether or not the device is addressed.
// - local lockout disables the front-panel local key.
// - device clear returns the instrument to its power-up state; the decoder clears only serial poll, service request and receive data.
// - serial poll enable enters serial poll mode.
// - serial poll disable leaves serial poll mode regardless of addressing.
// - addressed commands act only while listen addressed.
// - selective clear while listening equals device clear; ignored otherwise.
// - go-to-local while listening leaves remote mode; lockout is kept.
// - group execute trigger starts the trigger action.
// - primary address ORed with 20 is the listen address.
// - primary address ORed with 40 is the talk address.
// - secondary command bytes change no addressing state.
// - unlisten idles the listener.
// - untalk idles the talker.
// - command codes 01,04,08,11,14,18,19,3F,5F.
// - primary address is five bits, zero to thirty.
// - every byte moves by the interlocked three-wire handshake.
`timescale 1ns/1ps
`include "gbcd_consts.svh"
module gbcd_top (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // bus pins, low true
  input  wire logic [7:0]  dio_n_i,
  input  wire logic        atn_n_i,
  input  wire logic        ifc_n_i,
  input  wire logic        ren_n_i,
  input  wire logic        eoi_n_i,
  input  wire logic        dav_n_i,
  input  wire logic        nrfd_n_i,
  output logic             nrfd_n_o,
  output logic             nrfd_oe_n_o,
  input  wire logic        ndac_n_i,
  output logic             ndac_n_o,
  output logic             ndac_oe_n_o,
  input  wire logic        srq_n_i,
  output logic             srq_n_o,
  output logic             srq_oe_n_o,
  // instrument side
  input  wire logic        local_key_i,
  output logic [7:0]       msg_data_o,
  output logic             msg_eoi_o,
  output logic             msg_valid_o,
  output logic             dev_clear_o,
  output logic             trigger_o,
  output logic             remote_o,
  output logic             lockout_o,
  output logic             spoll_o,
  output logic             listen_o,
  output logic             talk_o
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  logic [13:0] pin;
  logic        atn;
  logic        ifc;
  logic        ren;
  logic        key;

  // lines are inverted so that a low line reads as true
  gbcd_sync #(.W(14)) u_sync (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .async_i   ({local_key_i, ~dav_n_i, ~eoi_n_i, ~ren_n_i, ~ifc_n_i, ~atn_n_i, ~dio_n_i}),
    .sync_o    (pin)
  );

  assign atn = pin[8];
  assign ifc = pin[9];
  assign ren = pin[10];
  assign key = pin[13];

  ////////////////////////////////////////////////////////////////////////////
  // byte acceptor
  gbcd_byte_if        bif ();
  gbcd_pkg::gbcd_core_t q, d;

  gbcd_acceptor u_acc (
    .ref_clk_i   (ref_clk_i),
    .resetn_i    (resetn_i),
    .active_i    (atn | q.listen),
    .ifc_i       (ifc),
    .dav_i       (pin[12]),
    .atn_i       (atn),
    .eoi_i       (pin[11]),
    .dio_i       (pin[7:0]),
    .nrfd_oe_n_o (nrfd_oe_n_o),
    .ndac_oe_n_o (ndac_oe_n_o),
    .byte_o      (bif)
  );

  // commands are never stalled; data waits for the receive register to empty
  assign bif.ready = bif.atn | ~q.rx_full;

  logic       take;
  logic [6:0] cmd;
  logic       acc;
  logic       cmd_take;

  assign take     = bif.valid & bif.ready;
  assign cmd      = bif.data[6:0];
  assign cmd_take = take & bif.atn & ~ifc;
  assign acc      = hsel_i & htrans_i[1] & hready_i;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d        = q;
    d.clr_p  = 1'b0;
    d.trig_p = 1'b0;
    d.msg_v  = 1'b0;
    d.key_q  = key;
    d.ifc_q  = ifc;
    // data phase of a write
    if (q.dp_wr) begin
      case (q.dp_addr)
        `GBCD_OFF_CTRL: begin
          d.paddr = hwdata_i[4:0];
          d.srq   = hwdata_i[`GBCD_CTRL_SRQ];
        end
        `GBCD_OFF_EVT: d.evt = q.evt & ~hwdata_i[2:0];
        default: ;
      endcase
    end
    // bus command decode
    if (cmd_take) begin
      if (cmd == `GBCD_CMD_UNL) begin
        d.listen = 1'b0;
      end else if (cmd == `GBCD_CMD_UNT) begin
        d.talk = 1'b0;
      end else if ((cmd & `GBCD_GRP_MASK) == `GBCD_GRP_LAG) begin
        if (cmd == (`GBCD_GRP_LAG | {2'h0, q.paddr})) begin
          d.listen = 1'b1;
          if (ren) d.remote = 1'b1;
        end
      end else if ((cmd & `GBCD_GRP_MASK) == `GBCD_GRP_TAG) begin
        // another talker's address takes the talk role away from us
        d.talk = (cmd == (`GBCD_GRP_TAG | {2'h0, q.paddr}));
      end else if ((cmd & `GBCD_GRP_MASK) == `GBCD_GRP_SCG) begin
        d.talk = q.talk;
      end else begin
        case (cmd)
          `GBCD_CMD_LLO: d.lockout = 1'b1;
          `GBCD_CMD_DCL: d.clr_p   = 1'b1;
          `GBCD_CMD_SPE: d.spoll   = 1'b1;
          `GBCD_CMD_SPD: d.spoll   = 1'b0;
          `GBCD_CMD_SDC: d.clr_p   = q.listen;
          `GBCD_CMD_GET: d.trig_p  = q.listen;
          `GBCD_CMD_GTL: if (q.listen) d.remote = 1'b0;
          default: ;
        endcase
      end
    end
    // device clear lands one cycle after the command byte
    if (q.clr_p) begin
      d.spoll   = 1'b0;
      d.srq     = 1'b0;
      d.rx_full = 1'b0;
    end
    // front-panel local key, disabled under lockout
    if (key && !q.key_q && !q.lockout) d.remote = 1'b0;
    if (!ren) begin
      d.remote  = 1'b0;
      d.lockout = 1'b0;
    end
    if (ifc) begin
      d.listen = 1'b0;
      d.talk   = 1'b0;
      d.spoll  = 1'b0;
    end
    // address phase: read data is registered from the updated state
    d.dp_wr = acc & hwrite_i;
    if (acc) d.dp_addr = haddr_i[11:0];
    if (acc && !hwrite_i) begin
      case (haddr_i[11:0])
        `GBCD_OFF_CTRL: d.rdata = {23'h000000, d.srq, 3'h0, d.paddr};
        `GBCD_OFF_STAT: d.rdata = {24'h000000, d.srq, atn, ren, d.spoll, d.lockout, d.remote, d.talk, d.listen};
        `GBCD_OFF_RXD:  d.rdata = {22'h000000, d.rx_full, d.rx_eoi, d.rx_data};
        `GBCD_OFF_EVT:  d.rdata = {29'h00000000, d.evt};
        default:        d.rdata = 32'h00000000;
      endcase
      if (haddr_i[11:0] == `GBCD_OFF_RXD) d.rx_full = 1'b0;
    end
    // a new data byte wins over the pop of the register in the same cycle
    if (take && !bif.atn) begin
      d.rx_data = bif.data;
      d.rx_eoi  = bif.eoi;
      d.rx_full = 1'b1;
      d.msg_v   = 1'b1;
      d.msg_d   = bif.data;
      d.msg_eoi = bif.eoi;
    end
    // sticky events: the set wins over a write-one-to-clear
    if (q.clr_p) d.evt[`GBCD_EVT_CLR] = 1'b1;
    if (q.trig_p) d.evt[`GBCD_EVT_TRIG] = 1'b1;
    if (ifc && !q.ifc_q) d.evt[`GBCD_EVT_IFC] = 1'b1;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) q <= '0;
    else q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = q.rdata;
  // attention, clear and remote enable have no drivers here at all
  assign nrfd_n_o    = 1'b0;
  assign ndac_n_o    = 1'b0;
  assign srq_n_o     = 1'b0;
  assign srq_oe_n_o  = ~q.srq;
  assign msg_data_o  = q.msg_d;
  assign msg_eoi_o   = q.msg_eoi;
  assign msg_valid_o = q.msg_v;
  assign dev_clear_o = q.clr_p;
  assign trigger_o   = q.trig_p;
  assign remote_o    = q.remote;
  assign lockout_o   = q.lockout;
  assign spoll_o     = q.spoll;
  assign listen_o    = q.listen;
  assign talk_o      = q.talk;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  logic ctrl_wr;
  assign ctrl_wr = q.dp_wr && q.dp_addr == `GBCD_OFF_CTRL;

  sequence s_cmd(logic [6:0] c);
    cmd_take && cmd == c;
  endsequence

  sequence s_own_lad;
    cmd_take && cmd == (`GBCD_GRP_LAG | {2'h0, q.paddr});
  endsequence

  atn_no_data_a: assert property (take && bif.atn |=> !msg_valid_o)
    else $error("command byte leaked as data");
  data_path_a: assert property (
    take && !bif.atn |=> msg_valid_o && msg_data_o == $past(bif.data) && q.rx_full)
    else $error("data byte not delivered");
  srq_hold_a: assert property (q.srq && !q.clr_p && !ctrl_wr |=> !srq_oe_n_o)
    else $error("service request dropped");
  ren_local_a: assert property (!ren |=> !remote_o && !lockout_o)
    else $error("remote kept without enable");
  eoi_mark_a: assert property (take && !bif.atn |=> msg_eoi_o == $past(bif.eoi))
    else $error("end flag lost");
  ifc_idle_a: assert property (ifc |=> !listen_o && !talk_o && !spoll_o)
    else $error("interface clear ignored");
  dcl_any_a: assert property (s_cmd(`GBCD_CMD_DCL) |=> dev_clear_o ##1 !spoll_o && srq_oe_n_o)
    else $error("device clear not executed");
  llo_lock_a: assert property (s_cmd(`GBCD_CMD_LLO) and ren |=> lockout_o)
    else $error("lockout not set");
  key_locked_a: assert property (lockout_o && remote_o && ren && !cmd_take ##1 ren && !cmd_take |=> remote_o)
    else $error("local key left remote under lockout");
  spe_set_a: assert property (s_cmd(`GBCD_CMD_SPE) |=> spoll_o)
    else $error("serial poll not entered");
  spd_clr_a: assert property (s_cmd(`GBCD_CMD_SPD) |=> !spoll_o)
    else $error("serial poll not left");
  sdc_gate_a: assert property (
    dev_clear_o |-> $past(cmd == `GBCD_CMD_DCL || (cmd == `GBCD_CMD_SDC && q.listen)) && $past(cmd_take))
    else $error("clear without cause");
  gtl_local_a: assert property (s_cmd(`GBCD_CMD_GTL) and q.listen |=> !remote_o)
    else $error("go to local ignored");
  get_trig_a: assert property (
    s_cmd(`GBCD_CMD_GET) |=> trigger_o == $past(q.listen))
    else $error("trigger gating wrong");
  lad_listen_a: assert property (s_own_lad and (cmd != `GBCD_CMD_UNL) |=> listen_o)
    else $error("own listen address missed");
  tad_talk_a: assert property (
    cmd_take && cmd == (`GBCD_GRP_TAG | {2'h0, q.paddr}) && cmd != `GBCD_CMD_UNT |=> talk_o)
    else $error("own talk address missed");
  scg_keep_a: assert property (
    cmd_take && (cmd & `GBCD_GRP_MASK) == `GBCD_GRP_SCG |=> $stable(listen_o) && $stable(talk_o))
    else $error("secondary byte changed addressing");
  unl_idle_a: assert property (s_cmd(`GBCD_CMD_UNL) |=> !listen_o)
    else $error("unlisten ignored");
  unt_idle_a: assert property (s_cmd(`GBCD_CMD_UNT) |=> !talk_o)
    else $error("untalk ignored");
  unk_ignore_a: assert property (
    s_cmd(7'h02) and (q.paddr != 5'h02) |=> $stable(listen_o) && $stable(spoll_o) && !dev_clear_o && !trigger_o)
    else $error("unknown command had an effect");
endmodule // gbcd_top

// ===== testbench/gbcd_ctl_model.sv
// gbcd_ctl_model: behavioural active bus controller for the decoder bench
// assumes: lines are low true with pull-ups; the model only sources bytes
`timescale 1ns/1ps
module gbcd_ctl_model (
  // clock and wire levels
  input  wire logic ref_clk_i,
  input  wire logic nrfd_i,
  input  wire logic ndac_i,
  // controller lines
  output logic [7:0] dio_n_o,
  output logic       atn_n_o,
  output logic       ifc_n_o,
  output logic       ren_n_o,
  output logic       eoi_n_o,
  output logic       dav_n_o
);
  // all lines start released, which reads as false
  initial begin
    dio_n_o = 8'hFF;
    atn_n_o = 1'h1;
    ifc_n_o = 1'h1;
    ren_n_o = 1'h1;
    eoi_n_o = 1'h1;
    dav_n_o = 1'h1;
  end

  //////////////////////////////////////////////////////////////
  // one byte through the interlocked handshake; gap makes a slow source
  task automatic send(input logic [7:0] b, input logic atn, input logic eoi, input int gap, output logic ok);
    int n;
    ok = 1'h1;
    @(posedge ref_clk_i);
    atn_n_o <= ~atn;
    dio_n_o <= ~b;
    eoi_n_o <= ~eoi;
    n = 0;
    while (!(nrfd_i === 1'h1 && ndac_i === 1'h0) && n < 200) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 200) ok = 1'h0;
    // data settles at least one clock before valid
    repeat (gap + 1) @(posedge ref_clk_i);
    dav_n_o <= 1'h0;
    n = 0;
    while (ndac_i !== 1'h1 && n < 200) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 200) ok = 1'h0;
    dav_n_o <= 1'h1;
    dio_n_o <= 8'hFF;
    eoi_n_o <= 1'h1;
  endtask

  task automatic pulse_ifc();
    @(posedge ref_clk_i);
    ifc_n_o <= 1'h0;
    repeat (4) @(posedge ref_clk_i);
    ifc_n_o <= 1'h1;
  endtask

  task automatic set_ren(input logic on);
    @(posedge ref_clk_i);
    ren_n_o <= ~on;
  endtask
endmodule // gbcd_ctl_model

// ===== testbench/test_gpib_bus_command_decoder.sv
// test_gpib_bus_command_decoder: self-checking bench of the bus command decoder
// assumes: controller model on the bus side; bench is the AHB-Lite master
`timescale 1ns/1ps
`include "gbcd_consts.svh"
module test_gpib_bus_command_decoder;
  logic        ref_clk_i;
  logic        resetn_i;
  logic        hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  dio_n, msg_data, b;
  logic        atn_n, ifc_n, ren_n, eoi_n, dav_n, local_key, e;
  logic        nrfd_n, nrfd_oe_n, ndac_n, ndac_oe_n, srq_n, srq_oe_n;
  logic        msg_eoi, msg_valid, dev_clear, trigger, remote, lockout, spoll, listen, talk;
  logic [4:0]  pa;
  logic [7:0]  cb [18];
  logic [4:0]  cs [18];
  logic [11:0] exp_q [$];
  int          fail_count = 0;
  int          num_checks = 0;

  initial ref_clk_i = 1'h0;
  always #12.5 ref_clk_i = ~ref_clk_i;

  gbcd_top uut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
    .hresp_o(hresp), .hrdata_o(hrdata), .dio_n_i(dio_n), .atn_n_i(atn_n), .ifc_n_i(ifc_n), .ren_n_i(ren_n),
    .eoi_n_i(eoi_n), .dav_n_i(dav_n), .nrfd_n_i(nrfd_oe_n | nrfd_n), .nrfd_n_o(nrfd_n),
    .nrfd_oe_n_o(nrfd_oe_n), .ndac_n_i(ndac_oe_n | ndac_n), .ndac_n_o(ndac_n), .ndac_oe_n_o(ndac_oe_n),
    .srq_n_i(srq_oe_n | srq_n), .srq_n_o(srq_n), .srq_oe_n_o(srq_oe_n), .local_key_i(local_key),
    .msg_data_o(msg_data), .msg_eoi_o(msg_eoi), .msg_valid_o(msg_valid), .dev_clear_o(dev_clear),
    .trigger_o(trigger), .remote_o(remote), .lockout_o(lockout), .spoll_o(spoll), .listen_o(listen),
    .talk_o(talk));

  gbcd_ctl_model ctl (.ref_clk_i(ref_clk_i), .nrfd_i(nrfd_oe_n | nrfd_n), .ndac_i(ndac_oe_n | ndac_n),
    .dio_n_o(dio_n), .atn_n_o(atn_n), .ifc_n_o(ifc_n), .ren_n_o(ren_n), .eoi_n_o(eoi_n), .dav_n_o(dav_n));

  //////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks made %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic stuck();
    fail_count++;
    $display("wrong value at %0t ns: wait ran out", $time);
    report_and_stop();
  endtask

  // single word transfer; the master holds each phase until hready is seen high
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    hsel <= 1'h1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin @(posedge ref_clk_i); n++; end while (hready !== 1'h1 && n < 50);
    if (n >= 50) stuck();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge ref_clk_i); n++; end while (hready !== 1'h1 && n < 100);
    if (n >= 100) stuck();
    d = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic tx(input logic [7:0] v, input logic atn, input logic eoi);
    logic ok;
    ctl.send(v, atn, eoi, $urandom_range(3), ok);
    if (ok !== 1'h1) stuck();
  endtask

  // every pulse must match the oldest note; a pulse with no note is a mismatch
  always @(posedge ref_clk_i) begin
    if (resetn_i === 1'h1 && (msg_valid | dev_clear | trigger) === 1'h1) begin
      if (exp_q.size() == 0) check({20'h0, trigger, dev_clear, msg_valid, msg_eoi, msg_data}, 32'h0);
      else check({20'h0, trigger, dev_clear, msg_valid, msg_eoi, msg_data}, {20'h0, exp_q.pop_front()});
    end
  end

  //////////////////////////////////////////////////////////////
  initial begin
    {resetn_i, hsel, hwrite, local_key} = 4'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    void'($urandom(80));
    repeat (20) @(posedge ref_clk_i);
    resetn_i <= 1'h1;
    pa = 5'($urandom_range(30));
    ahb(1'h1, `GBCD_OFF_STAT, 32'hFFFF_FFFF, rd);
    ahb(1'h0, `GBCD_OFF_STAT, 32'h0, rd);
    check(rd, 32'h0);
    ahb(1'h0, 12'h010, 32'h0, rd);
    check(rd, 32'h0);
    check({29'h0, srq_oe_n, nrfd_oe_n, ndac_oe_n}, 32'h7);
    $display("test reset and registers done");

    ahb(1'h1, `GBCD_OFF_CTRL, 32'h100 | {27'h0, pa}, rd);
    ahb(1'h0, `GBCD_OFF_CTRL, 32'h0, rd);
    check(rd, 32'h100 | {27'h0, pa});
    check({31'h0, srq_oe_n}, 32'h0);
    ctl.set_ren(1'h1);
    // codes and expected {spoll, lockout, remote, talk, listen} after each
    cb = '{{3'h1, pa}, {3'h2, pa}, {3'h2, pa ^ 5'h1}, {3'h2, pa}, {3'h3, pa}, 8'h02, 8'h11, 8'h18, 8'h08,
      8'h19, 8'h01, 8'h04, 8'h5F, 8'h3F, 8'h08, 8'h04, 8'h14, {3'h1, pa}};
    cs = '{5'h05, 5'h07, 5'h05, 5'h07, 5'h07, 5'h07, 5'h0F, 5'h1F, 5'h1F, 5'h0F, 5'h0B, 5'h0B, 5'h09, 5'h08,
      5'h08, 5'h08, 5'h08, 5'h0D};
    for (int i = 0; i < 18; i++) begin
      if (i == 8) exp_q.push_back(12'h800);
      if (i == 11 || i == 16) exp_q.push_back(12'h400);
      tx(cb[i], 1'h1, 1'h0);
      ahb(1'h0, `GBCD_OFF_STAT, 32'h0, rd);
      check({22'h0, rd[4:0], spoll, lockout, remote, talk, listen}, {22'h0, cs[i], cs[i]});
      if (i == 11) check({31'h0, srq_oe_n}, 32'h1);
    end
    ahb(1'h0, `GBCD_OFF_EVT, 32'h0, rd);
    check(rd, 32'h3);
    ahb(1'h1, `GBCD_OFF_EVT, 32'h3, rd);
    ahb(1'h0, `GBCD_OFF_EVT, 32'h0, rd);
    check(rd, 32'h0);
    // local key pressed under lockout must leave remote on
    local_key <= 1'h1;
    repeat (4) @(posedge ref_clk_i);
    local_key <= 1'h0;
    check({31'h0, remote}, 32'h1);
    $display("test command table done");

    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom);
      e = (i == 3);
      exp_q.push_back({3'h1, e, b});
      tx(b, 1'h0, e);
      ahb(1'h0, `GBCD_OFF_RXD, 32'h0, rd);
      check(rd, {22'h0, 1'h1, e, b});
    end
    $display("test data bytes done");

    tx({3'h2, pa}, 1'h1, 1'h0);
    ctl.pulse_ifc();
    ahb(1'h0, `GBCD_OFF_STAT, 32'h0, rd);
    check({26'h0, rd[5:0]}, 32'h2C);
    check({27'h0, spoll, lockout, remote, talk, listen}, 32'hC);
    ahb(1'h0, `GBCD_OFF_EVT, 32'h0, rd);
    check(rd, 32'h4);
    ctl.set_ren(1'h0);
    // let the two-flop synchroniser and the state register settle
    repeat (4) @(posedge ref_clk_i);
    ahb(1'h0, `GBCD_OFF_STAT, 32'h0, rd);
    check({26'h0, rd[5:0]}, 32'h0);
    // without lockout the local key returns the device to local
    ctl.set_ren(1'h1);
    tx({3'h1, pa}, 1'h1, 1'h0);
    check({31'h0, remote}, 32'h1);
    local_key <= 1'h1;
    repeat (4) @(posedge ref_clk_i);
    check({31'h0, remote}, 32'h0);
    local_key <= 1'h0;
    $display("test clear and remote enable done");
    check(32'(exp_q.size()), 32'h0);
    report_and_stop();
  end
endmodule // test_gpib_bus_command_decoder
